// ---- design/dfr_cfg.svh ----
`ifndef DFR_CFG_SVH
`define DFR_CFG_SVH
// register byte offsets
`define DFR_OFF_CFG        12'h000
`define DFR_OFF_STATUS     12'h004
`define DFR_OFF_MEM_RSP    12'h008
`define DFR_OFF_OUT        12'h00C
`define DFR_CFG_RST        32'h0000_0000
`define DFR_CFG_MASK       32'h0000_7FFF
// configuration field positions
`define DFR_B_OVD_DIS      0
`define DFR_B_UVD_DIS      1
`define DFR_B_OTMP_DIS     2
`define DFR_B_OOR_DIS      3
`define DFR_B_COIL_DIS     4
`define DFR_B_LBIST_DIS    5
`define DFR_B_DIAG_MODE    6
`define DFR_B_HIZ_RESP     7
`define DFR_B_SENT         8
`define DFR_B_SENT_DATA    9
`define DFR_F_LOCK_LO      10
`define DFR_F_LOCK_HI      12
`define DFR_F_COIL_LO      13
`define DFR_F_COIL_HI      14
`define DFR_LOCK_SET       3'h5
`define DFR_COIL_OFF       2'h3
// thresholds
`define DFR_OT_LIMIT_C     9'h0A0
`define DFR_COIL_TOL_PCT   20'h0000A
`define DFR_PCT_FULL       20'h00064
// read response error flags
`define DFR_RSP_SBE        28
`define DFR_RSP_DBE        29
// coded duty cycles, in tens of percent
`define DFR_DUTY_COIL      4'h3
`define DFR_DUTY_UV        4'h4
`define DFR_DUTY_OV        4'h6
`define DFR_DUTY_OT        4'h7
`define DFR_DUTY_OOR_LO    4'h8
`define DFR_DUTY_OOR_HI    4'h9
// timing
`define DFR_CLK_PERIOD_NS  5
`define DFR_PO_DELAY_NS    1000000
`define DFR_PO_CYC         ((`DFR_PO_DELAY_NS + `DFR_CLK_PERIOD_NS - 1) / `DFR_CLK_PERIOD_NS)
`endif

// ---- design/dfr_pkg.sv ----
package dfr_pkg;
   typedef enum logic [2:0] {
      DFR_ST_OFF   = 3'b001,
      DFR_ST_DELAY = 3'b010,
      DFR_ST_RUN   = 3'b100
   } dfr_state_t;
   typedef logic [3:0] dfr_duty_t;
endpackage

// ---- design/dfr_core.sv ----
`timescale 1ns/1ps
`include "dfr_cfg.svh"
module dfr_core
   import dfr_pkg::*;
#(
   parameter int unsigned PO_CYC = `DFR_PO_CYC
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        arst_n_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // analog indications
   input  wire logic        por_i,
   input  wire logic        uv_low_i,
   input  wire logic        uv_high_i,
   input  wire logic        ov_high_i,
   input  wire logic        ov_low_i,
   input  wire logic        hv_i,
   input  wire logic [8:0]  temp_c_i,
   input  wire logic        clamp_low_i,
   input  wire logic        clamp_high_i,
   input  wire logic        adc_under_i,
   input  wire logic        adc_over_i,
   input  wire logic        coil_sample_i,
   input  wire logic [15:0] coil_meas_i,
   input  wire logic [15:0] coil_ref_i,
   input  wire logic        lbist_fail_i,
   // memory read path
   input  wire logic        mem_rd_i,
   input  wire logic [25:0] mem_raw_i,
   input  wire logic [25:0] mem_flip_i,
   input  wire logic        mem_dbl_i,
   output logic      [31:0] mem_rsp_o,
   output logic             mem_rsp_valid_o,
   // output pin decision
   output logic             drive_en_o,
   output logic             normal_ok_o,
   output logic             half_rate_o,
   output logic      [3:0]  duty_code_o,
   output logic      [1:0]  status_comm_nibble_o,
   output logic      [7:0]  ext_flags_o,
   output logic             prog_mode_o,
   output logic             int_fault_o
);
   logic [1:0]  rst_sync_q;
   logic        rst_n;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // register bus: no wait states, pready rises in the first access cycle
   logic [31:0] cfg_q, cfg_d, prdata_d, rsp_q, rsp_d;
   logic        pready_q, pready_d, pslverr_d, done, mapped;
   logic [7:0]  diag_q, diag_d;
   always_comb begin
      done      = psel_i && penable_i && pready_q;
      mapped    = (paddr_i == `DFR_OFF_CFG) || (paddr_i == `DFR_OFF_STATUS) ||
                  (paddr_i == `DFR_OFF_MEM_RSP) || (paddr_i == `DFR_OFF_OUT);
      pready_d  = psel_i && !pready_q;
      pslverr_d = psel_i && !pready_q && !mapped;
      cfg_d     = cfg_q;
      if (done && pwrite_i && paddr_i == `DFR_OFF_CFG) begin
         cfg_d = pwdata_i & `DFR_CFG_MASK;
      end
      case (paddr_i)
         `DFR_OFF_CFG:     prdata_d = cfg_q;
         `DFR_OFF_STATUS:  prdata_d = {24'h00_0000, diag_q};
         `DFR_OFF_MEM_RSP: prdata_d = rsp_q;
         `DFR_OFF_OUT:     prdata_d = {16'h0000, ext_flags_o, 1'b0, prog_mode_o,
                                       status_comm_nibble_o, duty_code_o};
         default:          prdata_d = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q     <= `DFR_CFG_RST;
         pready_q  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         cfg_q     <= cfg_d;
         pready_q  <= pready_d;
         pslverr_o <= pslverr_d;
         prdata_o  <= prdata_d;
      end
   end
   assign pready_o = pready_q;
   logic       ovd_dis, uvd_dis, otmp_dis, oor_dis, coil_dis, lbist_dis;
   logic       diag1, hiz_resp, sent, sent_data, locked, coil_on;
   assign ovd_dis   = cfg_q[`DFR_B_OVD_DIS];
   assign uvd_dis   = cfg_q[`DFR_B_UVD_DIS];
   assign otmp_dis  = cfg_q[`DFR_B_OTMP_DIS];
   assign oor_dis   = cfg_q[`DFR_B_OOR_DIS];
   assign coil_dis  = cfg_q[`DFR_B_COIL_DIS];
   assign lbist_dis = cfg_q[`DFR_B_LBIST_DIS];
   assign hiz_resp  = cfg_q[`DFR_B_HIZ_RESP];
   assign sent      = cfg_q[`DFR_B_SENT];
   assign sent_data = cfg_q[`DFR_B_SENT_DATA];
   // diag mode 1 has no meaning in SENT, so it is ignored there
   assign diag1     = cfg_q[`DFR_B_DIAG_MODE] && !sent;
   assign locked    = cfg_q[`DFR_F_LOCK_HI:`DFR_F_LOCK_LO] == `DFR_LOCK_SET;
   assign coil_on   = cfg_q[`DFR_F_COIL_HI:`DFR_F_COIL_LO] != `DFR_COIL_OFF;
   // fault state with supply hysteresis
   logic        uv_q, uv_d, ov_q, ov_d, coil_q, coil_d, dbl_q, dbl_d;
   logic [15:0] cdiff;
   logic [22:0] cdev;
   always_comb begin
      uv_d = uv_q;
      if (uv_low_i) begin
         uv_d = 1'b1;
      end else if (uv_high_i) begin
         uv_d = 1'b0;
      end
      ov_d = ov_q;
      if (ov_high_i) begin
         ov_d = 1'b1;
      end else if (ov_low_i) begin
         ov_d = 1'b0;
      end
      cdiff  = (coil_meas_i > coil_ref_i) ? coil_meas_i - coil_ref_i
                                           : coil_ref_i - coil_meas_i;
      cdev   = {7'h00, cdiff} * {3'h0, `DFR_PCT_FULL};
      coil_d = coil_q;
      if (coil_sample_i) begin
         coil_d = cdev > {7'h00, coil_ref_i} * {3'h0, `DFR_COIL_TOL_PCT};
      end
      dbl_d = dbl_q || (mem_rd_i && mem_dbl_i);
   end
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         uv_q   <= 1'b0;
         ov_q   <= 1'b0;
         coil_q <= 1'b0;
         dbl_q  <= 1'b0;
      end else begin
         uv_q   <= uv_d;
         ov_q   <= ov_d;
         coil_q <= coil_d;
         dbl_q  <= dbl_d;
      end
   end
   // status byte, msb first: oor hi, oor lo, ot, ov, uv, coil, lbist, mem
   logic       oor_hi, oor_lo, ot, lbist_f;
   assign oor_hi  = (clamp_high_i || adc_over_i) && !oor_dis;
   assign oor_lo  = (clamp_low_i || adc_under_i) && !oor_dis;
   assign ot      = (temp_c_i > `DFR_OT_LIMIT_C) && !otmp_dis;
   assign lbist_f = lbist_fail_i && !lbist_dis;
   assign diag_d  = {oor_hi, oor_lo, ot, ov_q && locked && !ovd_dis, uv_q && !uvd_dis,
                     coil_q && coil_on && !coil_dis, lbist_f, dbl_q};
   // memory read response
   logic [31:0] rsp_w;
   always_comb begin
      rsp_w                = {6'h00, mem_raw_i ^ mem_flip_i};
      rsp_w[`DFR_RSP_SBE]  = |mem_flip_i && !mem_dbl_i;
      rsp_w[`DFR_RSP_DBE]  = mem_dbl_i;
      rsp_d                = mem_rd_i ? rsp_w : rsp_q;
   end
   // power-on sequencing
   dfr_state_t  st_q, st_d;
   logic [31:0] po_cnt_q, po_cnt_d;
   always_comb begin
      st_d     = st_q;
      po_cnt_d = po_cnt_q;
      case (st_q)
         DFR_ST_OFF: begin
            po_cnt_d = 32'h0000_0000;
            if (!por_i) begin
               st_d = DFR_ST_DELAY;
            end
         end
         DFR_ST_DELAY: begin
            po_cnt_d = po_cnt_q + 32'h0000_0001;
            if (por_i) begin
               st_d = DFR_ST_OFF;
            end else if (po_cnt_q >= PO_CYC - 1) begin
               st_d = DFR_ST_RUN;
            end
         end
         DFR_ST_RUN: begin
            if (por_i) begin
               st_d = DFR_ST_OFF;
            end
         end
         default: st_d = DFR_ST_OFF;
      endcase
   end
   // output decision, highest priority first
   logic       drv_d, ok_d, half_d, prog_d, any_f;
   logic [3:0] duty_d;
   logic [1:0] scn_d;
   always_comb begin
      drv_d  = 1'b0;
      ok_d   = 1'b0;
      half_d = 1'b0;
      duty_d = 4'h0;
      scn_d  = 2'b00;
      prog_d = ov_q && !locked && !hv_i;
      any_f  = |diag_d[7:2];
      if (hv_i) begin
         drv_d = 1'b0;
      end else if (por_i || (st_q != DFR_ST_RUN && (st_q == DFR_ST_OFF || !any_f))) begin
         drv_d = 1'b0;
      end else if (prog_d || lbist_f || dbl_q) begin
         drv_d = 1'b0;
      end else if (any_f) begin
         drv_d = !(hiz_resp || diag1);
         half_d = !sent && drv_d;
         if (diag_d[4]) begin
            duty_d = `DFR_DUTY_OV;
         end else if (diag_d[3]) begin
            duty_d = `DFR_DUTY_UV;
         end else if (diag_d[5]) begin
            duty_d = `DFR_DUTY_OT;
         end else if (diag_d[2]) begin
            duty_d = `DFR_DUTY_COIL;
         end else if (diag_d[6]) begin
            duty_d = `DFR_DUTY_OOR_LO;
         end else begin
            duty_d = `DFR_DUTY_OOR_HI;
         end
         if (sent || !drv_d) begin
            duty_d = 4'h0;
         end
         scn_d = {|diag_d[7:3], diag_d[2]} & {2{sent && drv_d}};
      end else begin
         drv_d = 1'b1;
         ok_d  = 1'b1;
      end
   end

   logic [7:0] ext_d;
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_rev
         assign ext_d[gi] = diag_d[7 - gi] && sent && sent_data;
      end
   endgenerate
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q                 <= DFR_ST_OFF;
         po_cnt_q             <= 32'h0000_0000;
         diag_q               <= 8'h00;
         rsp_q                <= 32'h0000_0000;
         mem_rsp_o            <= 32'h0000_0000;
         mem_rsp_valid_o      <= 1'b0;
         drive_en_o           <= 1'b0;
         normal_ok_o          <= 1'b0;
         half_rate_o          <= 1'b0;
         duty_code_o          <= 4'h0;
         status_comm_nibble_o <= 2'b00;
         ext_flags_o          <= 8'h00;
         prog_mode_o          <= 1'b0;
         int_fault_o          <= 1'b0;
      end else begin
         st_q                 <= st_d;
         po_cnt_q             <= po_cnt_d;
         diag_q               <= diag_d;
         rsp_q                <= rsp_d;
         mem_rsp_o            <= rsp_d;
         mem_rsp_valid_o      <= mem_rd_i;
         drive_en_o           <= drv_d;
         normal_ok_o          <= ok_d;
         half_rate_o          <= half_d;
         duty_code_o          <= duty_d;
         status_comm_nibble_o <= scn_d;
         ext_flags_o          <= ext_d;
         prog_mode_o          <= prog_d;
         int_fault_o          <= dbl_d;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);
   a_hv_hiz: assert property (hv_i |=> !drive_en_o)
      else $error("drive enabled during high voltage");
   a_por_hiz: assert property (st_q == DFR_ST_OFF |=> !drive_en_o)
      else $error("drive enabled during power-on reset");
   a_po_wait: assert property ($fell(por_i) |=> !normal_ok_o [*2])
      else $error("normal data before power-on delay");
   a_dbl_hiz: assert property (mem_rd_i && mem_dbl_i |=> ##1 !drive_en_o && int_fault_o)
      else $error("double error did not force hi-z");
   a_rsp_top: assert property (mem_rd_i && !mem_dbl_i && mem_flip_i == 26'h0
                               |=> mem_rsp_o[31:26] == 6'h00)
      else $error("read response top bits not zero");
   a_rsp_sbe: assert property (mem_rd_i && |mem_flip_i && !mem_dbl_i
                               |=> mem_rsp_o[28] && !mem_rsp_o[29])
      else $error("single error flag missing");
   a_rsp_dbe: assert property (mem_rd_i && mem_dbl_i |=> mem_rsp_o[29])
      else $error("double error flag missing");
   a_lbist_hiz: assert property (lbist_fail_i && !lbist_dis |=> !drive_en_o)
      else $error("logic self-test fail not hi-z");
   a_uv_hold: assert property (uv_q && !uv_high_i && !uv_low_i |=> uv_q)
      else $error("undervoltage released early");
   a_ov_duty: assert property (diag_d[4] && drv_d && !sent |=> duty_code_o == 4'h6)
      else $error("overvoltage duty wrong");
   a_ext_rev: assert property (sent && sent_data |=> ext_flags_o[3] == $past(diag_d[4]))
      else $error("extended flags not reversed");
   c_uv_pwm: cover property (duty_code_o == 4'h4 && half_rate_o);
   c_sent_scn: cover property (status_comm_nibble_o == 2'b10);
   c_prog: cover property (prog_mode_o);
   c_run: cover property (st_q == DFR_ST_RUN && normal_ok_o);
endmodule // dfr_core

// ---- dv/dfr_ctrl_model.sv ----
`timescale 1ns/1ps
// controller view of the pin: 4'hF when released, else coded duty or 0 for data
module dfr_ctrl_model (
   // decision from the block
   input  wire logic       drive_en_i,
   input  wire logic       half_rate_i,
   input  wire logic [3:0] duty_code_i,
   // decoded result
   output logic      [3:0] seen_o
);
   // a released pin reads as its pull-up, never as the last duty
   assign seen_o = !drive_en_i ? 4'hF : (half_rate_i ? duty_code_i : 4'h0);
endmodule // dfr_ctrl_model

// ---- dv/dfr_core_tb.sv ----
`timescale 1ns/1ps
`include "dfr_cfg.svh"
module dfr_core_tb;
   logic        clk_i, arst_n_i, psel, penable, pwrite, por, uv_lo, uv_hi, ov_hi, ov_lo;
   logic        hv, coil_smp, lbist, mem_rd, mem_dbl, pready, pslverr, rsp_vld, drv_en;
   logic        normal_ok, half_rate, prog_mode, int_fault;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mem_rsp, rd;
   logic [8:0]  temp;
   logic [3:0]  oor, duty, seen;
   logic [15:0] coil_meas;
   logic [25:0] mem_raw, mem_flip;
   logic [1:0]  status_comm_nibble;
   logic [7:0]  ext_flags;
   logic        err;
   int          error_cnt, n_checks, cyc;
   localparam int PO = 10; // shortened power-on delay

   dfr_core #(.PO_CYC(PO)) dfr_core_inst (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .por_i(por), .uv_low_i(uv_lo),
      .uv_high_i(uv_hi), .ov_high_i(ov_hi), .ov_low_i(ov_lo), .hv_i(hv), .temp_c_i(temp),
      .clamp_low_i(oor[0]), .clamp_high_i(oor[1]), .adc_under_i(oor[2]),
      .adc_over_i(oor[3]), .coil_sample_i(coil_smp), .coil_meas_i(coil_meas),
      .coil_ref_i(16'h0064), .lbist_fail_i(lbist), .mem_rd_i(mem_rd), .mem_raw_i(mem_raw),
      .mem_flip_i(mem_flip), .mem_dbl_i(mem_dbl), .mem_rsp_o(mem_rsp),
      .mem_rsp_valid_o(rsp_vld), .drive_en_o(drv_en), .normal_ok_o(normal_ok),
      .half_rate_o(half_rate), .duty_code_o(duty), .status_comm_nibble_o(status_comm_nibble),
      .ext_flags_o(ext_flags), .prog_mode_o(prog_mode), .int_fault_o(int_fault));

   dfr_ctrl_model dfr_ctrl_model_inst (
      .drive_en_i(drv_en), .half_rate_i(half_rate), .duty_code_i(duty), .seen_o(seen));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // holds the request until pready is sampled high; the cycle timeout bounds the wait
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic mem(input logic [25:0] raw, input logic [25:0] flip, input logic dbl);
      @(posedge clk_i);
      mem_rd <= 1'b1; mem_raw <= raw; mem_flip <= flip; mem_dbl <= dbl;
      @(posedge clk_i);
      mem_rd <= 1'b0;
      @(posedge clk_i);
      chk("rsp_valid", rsp_vld, 1'b1);
   endtask

   initial begin
      arst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; por = 1'b1; uv_lo = 1'b0; uv_hi = 1'b1; ov_hi = 1'b0; ov_lo = 1'b1;
      hv = 1'b0; temp = 9'h019; oor = 4'h0; coil_smp = 1'b0; coil_meas = 16'h0064;
      lbist = 1'b0; mem_rd = 1'b0; mem_raw = 26'h0; mem_flip = 26'h0; mem_dbl = 1'b0;
      step(5);
      arst_n_i <= 1'b1;
      step(4);
      chk("seen", seen, 4'hF);
      por <= 1'b0;
      step(3);
      chk("normal_ok", normal_ok, 1'b0);
      step(PO + 2);
      chk("normal_ok", normal_ok, 1'b1);
      apb(1'b1, `DFR_OFF_CFG, 32'h0000_1400);
      apb(1'b0, `DFR_OFF_CFG, 32'h0);
      chk("cfg", rd, 32'h0000_1400);
      apb(1'b0, 12'h010, 32'h0);
      chk("pslverr", err, 1'b1);
      // undervoltage clears only on the high threshold
      uv_lo <= 1'b1; uv_hi <= 1'b0; step(4);
      chk("seen", seen, 4'h4);
      apb(1'b0, `DFR_OFF_STATUS, 32'h0);
      chk("status", rd, 32'h0000_0008);
      uv_lo <= 1'b0; step(4);
      chk("seen", seen, 4'h4);
      uv_hi <= 1'b1; step(4);
      chk("seen", seen, 4'h0);
      ov_hi <= 1'b1; ov_lo <= 1'b0; step(4);
      chk("seen", seen, 4'h6);
      ov_hi <= 1'b0; step(4);
      chk("seen", seen, 4'h6);
      ov_lo <= 1'b1; step(4);
      chk("seen", seen, 4'h0);
      temp <= 9'h0A1; step(4);
      chk("seen", seen, 4'h7);
      temp <= 9'h0A0; step(4);
      chk("seen", seen, 4'h0);
      for (int i = 0; i < 4; i++) begin
         oor <= 4'h1 << i; step(4);
         chk("seen", seen, i[0] ? 4'h9 : 4'h8);
      end
      oor <= 4'h0;
      // 10 percent deviation exactly is still good
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_i);
         coil_meas <= 16'h006E + i[15:0]; coil_smp <= 1'b1;
         @(posedge clk_i);
         coil_smp <= 1'b0; step(4);
         chk("seen", seen, i ? 4'h3 : 4'h0);
      end
      @(posedge clk_i);
      coil_meas <= 16'h0064; coil_smp <= 1'b1;
      @(posedge clk_i);
      coil_smp <= 1'b0;
      apb(1'b1, `DFR_OFF_CFG, 32'h0000_1700);
      uv_lo <= 1'b1; uv_hi <= 1'b0; step(4);
      chk("scn", status_comm_nibble, 2'h2);
      chk("ext_flags", ext_flags, 8'h10);
      apb(1'b1, `DFR_OFF_CFG, 32'h0000_1440); step(4);
      chk("seen", seen, 4'hF);
      apb(1'b1, `DFR_OFF_CFG, 32'h0000_1480); step(4);
      chk("seen", seen, 4'hF);
      uv_lo <= 1'b0; uv_hi <= 1'b1;
      apb(1'b1, `DFR_OFF_CFG, 32'h0000_1400);
      lbist <= 1'b1; step(4);
      chk("seen", seen, 4'hF);
      lbist <= 1'b0; hv <= 1'b1; step(4);
      chk("seen", seen, 4'hF);
      hv <= 1'b0;
      // every fault masked by its disable bit, coil monitor off
      apb(1'b1, `DFR_OFF_CFG, 32'h0000_743F);
      uv_lo <= 1'b1;
      uv_hi <= 1'b0;
      ov_hi <= 1'b1;
      ov_lo <= 1'b0;
      temp <= 9'h0A1;
      oor <= 4'h3;
      lbist <= 1'b1;
      coil_meas <= 16'h006F;
      coil_smp <= 1'b1;
      step(1);
      coil_smp <= 1'b0;
      step(4);
      chk("seen", seen, 4'h0);
      apb(1'b0, `DFR_OFF_STATUS, 32'h0);
      chk("status", rd, 32'h0000_0000);
      uv_lo <= 1'b0;
      uv_hi <= 1'b1;
      ov_hi <= 1'b0;
      ov_lo <= 1'b1;
      temp <= 9'h019;
      oor <= 4'h0;
      lbist <= 1'b0;
      coil_meas <= 16'h0064;
      coil_smp <= 1'b1;
      step(1);
      coil_smp <= 1'b0;
      apb(1'b1, `DFR_OFF_CFG, 32'h0);
      ov_hi <= 1'b1; ov_lo <= 1'b0; step(4);
      chk("prog_mode", prog_mode, 1'b1);
      chk("seen", seen, 4'hF);
      mem(26'h2AA_AAAA, 26'h0, 1'b0);
      chk("mem_rsp", mem_rsp, 32'h02AA_AAAA);
      mem(26'h000_1234, 26'h000_0010, 1'b0);
      chk("mem_rsp", mem_rsp, 32'h1000_1224);
      ov_hi <= 1'b0;
      ov_lo <= 1'b1;
      step(4);
      chk("drive_en", drv_en, 1'b1);
      mem(26'h000_1234, 26'h0, 1'b1);
      chk("rsp_top", mem_rsp[31:26], 6'h08);
      step(3);
      chk("int_fault", int_fault, 1'b1);
      chk("drive_en", drv_en, 1'b0);
      give_verdict();
   end
endmodule // dfr_core_tb
